// *** hw/aigc_pkg.sv ***
// Purpose : Constants for the converter input and gain configuration block
// Assumes : AXI4-Lite, 32-bit data, printed offsets are register indices
// Notes   : Byte address of a register is four times its index
package aigc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AIGC_IDX_INPUT = 8'h02;
  localparam logic [7:0] AIGC_IDX_GAIN  = 8'h03;
  localparam logic [7:0] AIGC_RST_INPUT = 8'h01;
  localparam logic [7:0] AIGC_RST_GAIN  = 8'h00;
  localparam int         AIGC_ADDR_W    = 12;
  localparam logic [1:0] AIGC_RESP_OKAY = 2'b00;
  localparam logic [1:0] AIGC_RESP_SLVERR = 2'b10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AIGC_POS_HI  = 7;
  localparam int AIGC_POS_LO  = 4;
  localparam int AIGC_NEG_HI  = 3;
  localparam int AIGC_NEG_LO  = 0;
  localparam int AIGC_DLY_HI  = 7;
  localparam int AIGC_DLY_LO  = 5;
  localparam int AIGC_EN_HI   = 4;
  localparam int AIGC_EN_LO   = 3;
  localparam int AIGC_GAIN_HI = 2;
  localparam int AIGC_GAIN_LO = 0;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] AIGC_SEL_COMMON = 4'hc;
  localparam logic [1:0] AIGC_AMP_BYPASS = 2'b00;
  localparam logic [1:0] AIGC_AMP_ON     = 2'b01;
  localparam logic [7:0] AIGC_GAIN_ONE   = 8'h01;
  // Delay in modulator clock periods per code
  localparam logic [12:0] AIGC_DLY_0 = 13'h000e;
  localparam logic [12:0] AIGC_DLY_1 = 13'h0019;
  localparam logic [12:0] AIGC_DLY_2 = 13'h0040;
  localparam logic [12:0] AIGC_DLY_3 = 13'h0100;
  localparam logic [12:0] AIGC_DLY_4 = 13'h0400;
  localparam logic [12:0] AIGC_DLY_5 = 13'h0800;
  localparam logic [12:0] AIGC_DLY_6 = 13'h1000;
  localparam logic [12:0] AIGC_DLY_7 = 13'h0001;
endpackage

// *** hw/aigc_regs.sv ***
// Purpose : Input selector and gain/delay configuration registers
// Assumes : Single clock aclk, synchronous active-low reset
// Notes   : A write with byte lane 0 to either register pulses the filter restart trigger
//
// The AXI4-Lite register port was chosen for this implementation.
module aigc_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       positive_input_select,
  output logic [3:0]       negative_input_select,
  output logic             positive_select_reserved,
  output logic             negative_select_reserved,
  output logic             amplifier_power_on,
  output logic             amplifier_enable_reserved,
  output logic [7:0]       amplifier_gain,
  output logic [12:0]      start_delay_periods,
  output logic             filter_restart
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Delay code to modulator clock periods
  function automatic logic [12:0] dly_decode(input logic [2:0] c);
    unique case (c)
      3'd0: dly_decode = aigc_pkg::AIGC_DLY_0;
      3'd1: dly_decode = aigc_pkg::AIGC_DLY_1;
      3'd2: dly_decode = aigc_pkg::AIGC_DLY_2;
      3'd3: dly_decode = aigc_pkg::AIGC_DLY_3;
      3'd4: dly_decode = aigc_pkg::AIGC_DLY_4;
      3'd5: dly_decode = aigc_pkg::AIGC_DLY_5;
      3'd6: dly_decode = aigc_pkg::AIGC_DLY_6;
      3'd7: dly_decode = aigc_pkg::AIGC_DLY_7;
    endcase
  endfunction

  // Selector code above the common input is reserved
  function automatic logic sel_reserved(input logic [3:0] c);
    sel_reserved = (c > aigc_pkg::AIGC_SEL_COMMON);
  endfunction

  // ----------------------------------------------------------------
  // Storage and bus state
  // ----------------------------------------------------------------
  logic [7:0]  input_selector_register_r;
  logic [7:0]  gain_delay_control_r;
  logic [11:0] awaddr_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        restart_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  // Both halves present; write commits in this cycle
  wire         wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire [9:0]   wr_idx  = awaddr_r[11:2];
  wire [9:0]   rd_idx  = s_axi_araddr[11:2];
  wire         wr_in   = (wr_idx == 10'(aigc_pkg::AIGC_IDX_INPUT));
  wire         wr_gain = (wr_idx == 10'(aigc_pkg::AIGC_IDX_GAIN));
  wire         rd_in   = (rd_idx == 10'(aigc_pkg::AIGC_IDX_INPUT));
  wire         rd_gain = (rd_idx == 10'(aigc_pkg::AIGC_IDX_GAIN));
  wire         wr_ok   = wr_in | wr_gain;
  wire         wr_lane = wstrb0_r;
  // Narrow registers sit in the low byte; upper bits read zero
  wire [31:0]  rd_mux  = rd_in   ? {24'h00_0000, input_selector_register_r} :
                         rd_gain ? {24'h00_0000, gain_delay_control_r} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~aw_take & ~wr_go;
      s_axi_wready  <= ~w_held_r & ~w_take & ~wr_go;
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped index answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= aigc_pkg::AIGC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? aigc_pkg::AIGC_RESP_OKAY : aigc_pkg::AIGC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Byte lane 0 carries the whole register; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_selector_register_r <= aigc_pkg::AIGC_RST_INPUT;
      gain_delay_control_r      <= aigc_pkg::AIGC_RST_GAIN;
      restart_r                 <= 1'b0;
    end else begin
      if (wr_go && wr_in && wr_lane) begin
        input_selector_register_r <= wdata_r[7:0];
      end
      if (wr_go && wr_gain && wr_lane) begin
        gain_delay_control_r <= wdata_r[7:0];
      end
      // Any stored change to either register restarts the filter
      restart_r <= wr_go & wr_ok & wr_lane;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Reads only return stored values; nothing else changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= aigc_pkg::AIGC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (rd_in | rd_gain) ? aigc_pkg::AIGC_RESP_OKAY : aigc_pkg::AIGC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode to analog controls
  // ----------------------------------------------------------------
  wire [3:0] pos_code  = input_selector_register_r[aigc_pkg::AIGC_POS_HI:aigc_pkg::AIGC_POS_LO];
  wire [3:0] neg_code  = input_selector_register_r[aigc_pkg::AIGC_NEG_HI:aigc_pkg::AIGC_NEG_LO];
  wire [2:0] dly_code  = gain_delay_control_r[aigc_pkg::AIGC_DLY_HI:aigc_pkg::AIGC_DLY_LO];
  wire [1:0] en_code   = gain_delay_control_r[aigc_pkg::AIGC_EN_HI:aigc_pkg::AIGC_EN_LO];
  wire [2:0] gain_code = gain_delay_control_r[aigc_pkg::AIGC_GAIN_HI:aigc_pkg::AIGC_GAIN_LO];
  // Reserved amplifier codes leave the amplifier off as a safe fallback
  wire       amp_on    = (en_code == aigc_pkg::AIGC_AMP_ON);

  // Outputs registered so they change one cycle after the stored value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      positive_input_select     <= aigc_pkg::AIGC_RST_INPUT[aigc_pkg::AIGC_POS_HI:aigc_pkg::AIGC_POS_LO];
      negative_input_select     <= aigc_pkg::AIGC_RST_INPUT[aigc_pkg::AIGC_NEG_HI:aigc_pkg::AIGC_NEG_LO];
      positive_select_reserved  <= 1'b0;
      negative_select_reserved  <= 1'b0;
      amplifier_power_on        <= 1'b0;
      amplifier_enable_reserved <= 1'b0;
      amplifier_gain            <= aigc_pkg::AIGC_GAIN_ONE;
      start_delay_periods       <= aigc_pkg::AIGC_DLY_0;
      filter_restart            <= 1'b0;
    end else begin
      positive_input_select     <= pos_code;
      negative_input_select     <= neg_code;
      positive_select_reserved  <= sel_reserved(pos_code);
      negative_select_reserved  <= sel_reserved(neg_code);
      amplifier_power_on        <= amp_on;
      amplifier_enable_reserved <= en_code[1];
      amplifier_gain            <= aigc_pkg::AIGC_GAIN_ONE << gain_code;
      start_delay_periods       <= dly_decode(dly_code);
      filter_restart            <= restart_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks: reset values and stored writes
  // ----------------------------------------------------------------
  // Accepted write to a mapped register with lane 0, at the commit edge
  sequence s_cfg_write;
    wr_go && wr_ok && wr_lane;
  endsequence
  // Restart trigger stays high for exactly one cycle
  sequence s_restart_pulse;
    filter_restart ##1 !filter_restart;
  endsequence
  // Both registers leave reset at their defaults
  a_input_reset_value: assert property (@(posedge aclk) $rose(aresetn) |->
    input_selector_register_r == aigc_pkg::AIGC_RST_INPUT)
    else $error("input selector not at reset value");
  a_gain_reset_value: assert property (@(posedge aclk) $rose(aresetn) |->
    gain_delay_control_r == aigc_pkg::AIGC_RST_GAIN)
    else $error("gain register not at reset value");
  // The word held in the write buffer lands in the addressed register
  a_input_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_in && wr_lane |=> input_selector_register_r == $past(wdata_r[7:0]))
    else $error("input selector write lost");
  a_gain_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_gain && wr_lane |=> gain_delay_control_r == $past(wdata_r[7:0]))
    else $error("gain register write lost");
  // A write to no register, or without lane 0, must change nothing
  a_refused_write_held: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !(wr_ok && wr_lane) |=> $stable(input_selector_register_r) && $stable(gain_delay_control_r))
    else $error("refused write changed a register");

  // ----------------------------------------------------------------
  // Checks: filter restart trigger
  // ----------------------------------------------------------------
  a_restart_after_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cfg_write |-> ##2 s_restart_pulse)
    else $error("restart pulse missing after write");
  a_no_spurious_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    filter_restart |-> $past(wr_go, 2) && $past(wr_ok, 2))
    else $error("restart without write");
  // Refused writes must not disturb a running conversion
  a_no_restart_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !(wr_ok && wr_lane) |-> ##2 !filter_restart)
    else $error("restart after refused write");

  // ----------------------------------------------------------------
  // Checks: decoded controls
  // ----------------------------------------------------------------
  // Each control is compared one cycle after the field it comes from
  a_pos_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 positive_input_select == $past(pos_code))
    else $error("positive select does not follow field");
  a_neg_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 negative_input_select == $past(neg_code))
    else $error("negative select does not follow field");
  a_pos_reserved_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 positive_select_reserved == ($past(pos_code) > aigc_pkg::AIGC_SEL_COMMON))
    else $error("positive reserved flag wrong");
  a_neg_reserved_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 negative_select_reserved == ($past(neg_code) > aigc_pkg::AIGC_SEL_COMMON))
    else $error("negative reserved flag wrong");
  // The common input is the last legal code, not a reserved one
  a_common_select: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_code == aigc_pkg::AIGC_SEL_COMMON ##1 pos_code == aigc_pkg::AIGC_SEL_COMMON |-> !positive_select_reserved)
    else $error("common input flagged reserved");
  // Delay codes at both ends of the table
  a_delay_first_code: assert property (@(posedge aclk) disable iff (!aresetn)
    dly_code == 3'd0 ##1 dly_code == 3'd0 |-> start_delay_periods == 13'd14)
    else $error("delay code zero not fourteen periods");
  a_delay_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    dly_code == 3'd7 ##1 dly_code == 3'd7 |-> start_delay_periods == 13'd1)
    else $error("delay code seven not one period");
  // Reserved enable codes leave the amplifier off but raise the flag
  a_amp_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 amplifier_power_on == ($past(en_code) == 2'b01))
    else $error("amplifier enable decode wrong");
  a_amp_reserved_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 amplifier_enable_reserved == ($past(en_code) inside {2'b10, 2'b11}))
    else $error("amplifier reserved flag wrong");
  // Gain codes at both ends of the range
  a_gain_unity: assert property (@(posedge aclk) disable iff (!aresetn)
    gain_code == 3'd0 ##1 gain_code == 3'd0 |-> amplifier_gain == 8'd1)
    else $error("gain code zero not unity");
  a_gain_power: assert property (@(posedge aclk) disable iff (!aresetn)
    gain_code == 3'd7 ##1 gain_code == 3'd7 |-> amplifier_gain == 8'd128)
    else $error("gain code seven not 128");

  // ----------------------------------------------------------------
  // Checks: register reads
  // ----------------------------------------------------------------
  a_read_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && !wr_go |=> $stable(input_selector_register_r) && $stable(gain_delay_control_r))
    else $error("read changed configuration");
  // Read data is the stored byte, zero-extended, one cycle after the address
  a_read_input_data: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_in |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(input_selector_register_r)})
    else $error("input selector read data wrong");
  a_read_gain_data: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_gain |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(gain_delay_control_r)})
    else $error("gain register read data wrong");
endmodule

// *** test/adc_input_and_gain_config_bench.sv ***
// Purpose : Self-checking bench for the input and gain configuration registers
// Assumes : Bench is the AXI4-Lite master; one 200 MHz clock
// Notes   : Expected values come from the field codes, never from earlier reads
module adc_input_and_gain_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam logic [11:0] ADDR_IN   = {2'b00, aigc_pkg::AIGC_IDX_INPUT, 2'b00};
  localparam logic [11:0] ADDR_GAIN = {2'b00, aigc_pkg::AIGC_IDX_GAIN, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, positive_input_select, negative_input_select;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, filter_restart;
  logic positive_select_reserved, negative_select_reserved, amplifier_power_on, amplifier_enable_reserved;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] amplifier_gain;
  logic [12:0] start_delay_periods;
  int err_total = 0, comparisons = 0, restarts = 0;
  int dly [8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
  aigc_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
    .positive_select_reserved(positive_select_reserved), .negative_select_reserved(negative_select_reserved),
    .amplifier_power_on(amplifier_power_on), .amplifier_enable_reserved(amplifier_enable_reserved),
    .amplifier_gain(amplifier_gain), .start_delay_periods(start_delay_periods),
    .filter_restart(filter_restart));
  // Clock, restart pulse counter and watchdog; counting pulses catches a stuck-high trigger
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (filter_restart === 1'b1) restarts <= restarts + 1;
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Write, then let the restart pulse and the decoded outputs land
  task automatic write_set(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    int n;
    n = restarts;
    axi_write(a, d, 4'hf, r);
    `CHK(r, aigc_pkg::AIGC_RESP_OKAY)
    repeat (4) @(posedge aclk);
    #1;
    `CHK(restarts, n + 1)
  endtask
  // A read must return the stored byte and never trigger a restart
  task automatic check_reg(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = restarts;
    axi_read(a, d, r);
    `CHK(d, {24'h00_0000, e})
    `CHK(r, aigc_pkg::AIGC_RESP_OKAY)
    repeat (4) @(posedge aclk);
    #1;
    `CHK(restarts, n)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
  endtask
  task automatic t_defaults();
    `CHK(positive_input_select, 4'h0)
    `CHK(negative_input_select, 4'h1)
    `CHK(amplifier_gain, aigc_pkg::AIGC_GAIN_ONE)
    `CHK(start_delay_periods, 13'h000e)
    `CHK(amplifier_power_on, 1'b0)
    check_reg(ADDR_IN, 8'h01);
    check_reg(ADDR_GAIN, 8'h00);
  endtask
  // Every selector code on both fields, the reserved ones included; then a byte-masked write
  // The bench stands for the twelve-channel variant, so codes 6 to 11 are legal here
  task automatic t_inputs();
    logic [3:0] c;
    logic [1:0] r;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      write_set(ADDR_IN, {c, ~c});
      `CHK(positive_input_select, c)
      `CHK(negative_input_select, ~c)
      `CHK(positive_select_reserved, (c > 4'hc))
      `CHK(negative_select_reserved, (~c > 4'hc))
      check_reg(ADDR_IN, {c, ~c});
    end
    axi_write(ADDR_IN, 8'h55, 4'h0, r);
    `CHK(r, aigc_pkg::AIGC_RESP_OKAY)
    check_reg(ADDR_IN, 8'hf0);
  endtask
  // Every delay and gain code with the amplifier on, then every enable code in bypass gain
  task automatic t_gain();
    logic [2:0] c;
    logic [1:0] e;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      write_set(ADDR_GAIN, {c, aigc_pkg::AIGC_AMP_ON, c});
      `CHK(start_delay_periods, 13'(dly[i]))
      `CHK(amplifier_gain, 8'h01 << i)
      `CHK(amplifier_power_on, 1'b1)
      check_reg(ADDR_GAIN, {c, aigc_pkg::AIGC_AMP_ON, c});
    end
    for (int i = 0; i < 4; i++) begin
      e = 2'(i);
      write_set(ADDR_GAIN, {3'b111, e, 3'b000});
      `CHK(amplifier_power_on, (e == 2'b01))
      `CHK(amplifier_enable_reserved, e[1])
      `CHK(amplifier_gain, aigc_pkg::AIGC_GAIN_ONE)
      `CHK(start_delay_periods, 13'h0001)
    end
  endtask
  // Unmapped accesses are refused and leave both registers and the trigger alone
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = restarts;
    axi_write(12'h010, 8'h77, 4'hf, r);
    `CHK(r, aigc_pkg::AIGC_RESP_SLVERR)
    axi_read(12'h010, d, r);
    `CHK(r, aigc_pkg::AIGC_RESP_SLVERR)
    check_reg(ADDR_IN, 8'hf0);
    check_reg(ADDR_GAIN, 8'hf8);
    `CHK(restarts, n)
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence; the second reset checks recovery from a mid-run reset
  initial begin
    do_reset();
    t_defaults();
    t_inputs();
    t_gain();
    t_unmapped();
    do_reset();
    t_defaults();
    end_of_test();
  end
endmodule
